// >>> core/duc_pkg.sv
// shared constants, register map and state types for the dual uart channel pair
package duc_pkg;

  // ****************************************
  // structure
  // ****************************************
  localparam int NUM_CH     = 2;
  localparam int FIFO_DEPTH = 128;
  localparam int CNT_W      = 8;
  localparam int SYNC_W     = 3;

  // ****************************************
  // address decode, byte offsets inside one channel window
  // ****************************************
  localparam int         CHAN_SEL_BIT = 6;
  localparam int         NO_CHAN_BIT  = 7;
  localparam logic [5:0] OFS_DATA     = 6'h00;
  localparam logic [5:0] OFS_CTRL     = 6'h04;
  localparam logic [5:0] OFS_DIV      = 6'h08;
  localparam logic [5:0] OFS_TXLVL    = 6'h0C;
  localparam logic [5:0] OFS_RXLVL    = 6'h10;
  localparam logic [5:0] OFS_FLOWHI   = 6'h14;
  localparam logic [5:0] OFS_FLOWLO   = 6'h18;
  localparam logic [5:0] OFS_STATUS   = 6'h1C;
  localparam logic [5:0] OFS_ISTAT    = 6'h20;
  localparam logic [5:0] OFS_IMASK    = 6'h24;

  // ****************************************
  // control field positions and reset values
  // ****************************************
  localparam int          CTL_TX_EN    = 0;
  localparam int          CTL_RX_EN    = 1;
  localparam int          CTL_LOOP     = 2;
  localparam int          CTL_PAR_EN   = 3;
  localparam int          CTL_PAR_ODD  = 4;
  localparam int          CTL_DMA_BLK  = 5;
  localparam int          CTL_TRIG_LO  = 6;
  localparam int          CTL_SOFT_RST = 15;
  localparam logic [15:0] CTRL_RST     = 16'h0003;
  localparam logic [15:0] DIV_RST      = 16'h0364;

  // ****************************************
  // interrupt status bits
  // ****************************************
  localparam int IRQ_RX_TRIG = 0;
  localparam int IRQ_TX_TRIG = 1;
  localparam int IRQ_PARITY  = 2;
  localparam int IRQ_FRAME   = 3;
  localparam int IRQ_OVERRUN = 4;
  localparam int IRQ_W       = 5;

  // ****************************************
  // legacy trigger tables, indexed by the two-bit select
  // ****************************************
  localparam logic [7:0] RX_TRIG_TBL [4] = '{8'h08, 8'h10, 8'h18, 8'h1C};
  localparam logic [7:0] TX_TRIG_TBL [4] = '{8'h10, 8'h08, 8'h18, 8'h1E};

  typedef enum logic [0:0] {TX_IDLE, TX_RUN} duc_tx_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} duc_rx_state_e;

endpackage

// >>> core/duc_fifo.sv
// flip-flop fifo with valid/ready on both sides and an occupancy count
`timescale 1ns/1ps
module duc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 128,
  parameter int CW    = 8
) (
  input  wire logic          clk,      // system clock
  input  wire logic          rst_n,    // synchronous reset, active low
  input  wire logic          flush,    // drop all contents
  input  wire logic          wr_valid, // push request
  output logic               wr_ready, // room for one more
  input  wire logic [W-1:0]  wr_data,  // pushed word
  output logic               rd_valid, // head word present
  input  wire logic          rd_ready, // pop request
  output logic [W-1:0]       rd_data,  // head word
  output logic [CW-1:0]      count     // words held
);

  localparam int AW = $clog2(DEPTH);

  // pointers wrap by overflow, so the depth must be a power of two
  if ((1 << AW) != DEPTH || DEPTH >= (1 << CW)) begin : g_bad_depth
    $error("duc_fifo: depth must be a power of two below 2**CW");
  end

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic          push;
  logic          pop;

  // full and empty both come straight from the count
  assign wr_ready = (cnt_q != CW'(DEPTH));
  assign rd_valid = (cnt_q != '0);
  assign rd_data  = mem_q[rp_q];
  assign count    = cnt_q;
  assign push     = wr_valid & wr_ready;
  assign pop      = rd_valid & rd_ready;

  // pointers and count
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_q + AW'(push);
      rp_q  <= rp_q + AW'(pop);
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end

  // storage needs no reset, it is only read behind the count
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= wr_data;
    end
  end

endmodule

// >>> core/duc_top.sv
// dual uart channel pair: ahb-lite slave, two identical channels, dma ready pins
// How it works
// RULE_01: in single dma mode rx ready pin goes low once a received character waits in the fifo.
// RULE_02: in block dma mode rx ready pin stays high while fifo empty or trigger level not reached.
// RULE_03: tx ready pin is low while the transmit fifo has a free slot.
// RULE_04: in block dma mode tx ready goes high when the fifo is full.
// RULE_05: both ready pins also serve single-character dma transfers.
// RULE_06: serial out rests at one in reset, idle, and with transmitter off.
// RULE_07: loopback holds the out pin high and feeds tx data to the receiver.
// RULE_08: no select reaches nothing; address bit six picks channel a or b.
// RULE_09: transmitter adds start and stop bits; receiver strips them off.
// RULE_10: optional parity bit appended on transmit and checked on receive.
// RULE_11: each channel owns separate 128-entry transmit and receive fifos.
// RULE_12: legacy mode uses four fixed trigger levels; extended mode programmable.
// RULE_13: any reset returns the channel to legacy normal mode.
// RULE_14: host bus isolate input makes the register bus ignore all accesses.
// RULE_15: baud divisor and trigger levels are set through channel registers.
// RULE_16: in loopback the external serial input is ignored; it idles high.
// RULE_17: extended mode whenever any of the four level registers is nonzero.
// RULE_18: address bit seven high selects no channel; writes drop, reads zero.
// RULE_19: both channels are identical independent copies of the same logic.
//
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module duc_top #(
  parameter int DEPTH = duc_pkg::FIFO_DEPTH
) (
  input  wire logic        CLK_SYS,          // system clock, 100 mhz
  input  wire logic        RST_N,            // synchronous reset, active low
  input  wire logic        HSEL,             // ahb slave select
  input  wire logic [31:0] HADDR,            // ahb address
  input  wire logic [1:0]  HTRANS,           // ahb transfer type
  input  wire logic        HWRITE,           // ahb write
  input  wire logic [2:0]  HSIZE,            // ahb size, word only
  input  wire logic        HREADY,           // ahb bus ready
  input  wire logic [31:0] HWDATA,           // ahb write data
  output logic [31:0]      HRDATA,           // ahb read data
  output logic             HREADYOUT,        // ahb slave ready
  output logic             HRESP,            // ahb response, always okay
  input  wire logic        HOST_BUS_ISOLATE, // low-power bus isolation pin
  input  wire logic        SERIAL_IN_CHAN_A, // serial receive pin a
  input  wire logic        SERIAL_IN_CHAN_B, // serial receive pin b
  output logic             SERIAL_OUT_CHAN_A, // serial transmit pin a
  output logic             SERIAL_OUT_CHAN_B, // serial transmit pin b
  output logic             RX_READY_N_CHAN_A, // receive ready a, active low
  output logic             RX_READY_N_CHAN_B, // receive ready b, active low
  output logic             TX_READY_N_CHAN_A, // transmit ready a, active low
  output logic             TX_READY_N_CHAN_B, // transmit ready b, active low
  output logic             IRQ               // level interrupt, high active
);

  localparam int NCH = duc_pkg::NUM_CH;
  localparam int CW  = duc_pkg::CNT_W;

  // counts and trigger levels are eight bits wide
  if (DEPTH < 2 || DEPTH > 128) begin : g_bad_depth
    $error("duc_top: fifo depth must lie in 2..128");
  end

  // ****************************************
  // bus slave
  // ****************************************
  logic        pend_q;
  logic        wr_q;
  logic [7:0]  addr_q;
  logic [31:0] rdata_q;
  logic [duc_pkg::SYNC_W-1:0] iso_sync_q;
  logic        iso_q;
  logic        irq_q;
  logic        accept;
  logic        live;
  logic        busw;
  logic        busr;
  logic [5:0]  ofs;
  logic [31:0] rd_val [NCH];
  logic [NCH-1:0] irq_ch;
  logic        si [NCH];
  logic        so [NCH];
  logic        rxr_n [NCH];
  logic        txr_n [NCH];

  assign accept = HSEL & HTRANS[1] & HREADY;

  // address phase capture; one wait state gives registered read data
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      pend_q <= 1'b0;
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      pend_q <= accept;
      if (accept) begin
        wr_q   <= HWRITE;
        addr_q <= HADDR[7:0];
      end
    end
  end

  // the isolate pin is asynchronous: three stages, change once two agree
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      iso_sync_q <= 3'h0;
      iso_q      <= 1'b0;
    end else begin
      iso_sync_q <= {iso_sync_q[1:0], HOST_BUS_ISOLATE};
      if (iso_sync_q[1] == iso_sync_q[2]) begin
        iso_q <= iso_sync_q[2];
      end
    end
  end

  // a transfer still completes while isolated, it just touches nothing
  assign live = pend_q & ~iso_q & ~addr_q[duc_pkg::NO_CHAN_BIT]; // RULE_08 RULE_14 RULE_18
  assign busw = live & wr_q;
  assign busr = live & ~wr_q;
  assign ofs  = addr_q[5:0];

  // read data latched at the end of the wait state, zero if nothing selected
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rdata_q <= 32'h0000_0000;
    end else if (pend_q) begin
      rdata_q <= busr ? rd_val[addr_q[duc_pkg::CHAN_SEL_BIT]] : 32'h0000_0000; // RULE_18
    end
  end

  // interrupt output registered from both channels
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |irq_ch;
    end
  end

  assign HRDATA    = rdata_q;
  assign HREADYOUT = ~pend_q;
  assign HRESP     = 1'b0;
  assign IRQ       = irq_q;

  // pin mapping onto channel arrays
  assign si[0]             = SERIAL_IN_CHAN_A;
  assign si[1]             = SERIAL_IN_CHAN_B;
  assign SERIAL_OUT_CHAN_A = so[0];
  assign SERIAL_OUT_CHAN_B = so[1];
  assign RX_READY_N_CHAN_A = rxr_n[0];
  assign RX_READY_N_CHAN_B = rxr_n[1];
  assign TX_READY_N_CHAN_A = txr_n[0];
  assign TX_READY_N_CHAN_B = txr_n[1];

  // ****************************************
  // channels
  // ****************************************
  for (genvar c = 0; c < NCH; c++) begin : g_ch // RULE_19
    logic        me;
    logic        we;
    logic        re;
    logic        srst;
    logic        crst;
    logic        ext;
    logic        ext_q;
    logic        flush;
    logic [15:0] ctrl_q;
    logic [15:0] div_q;
    logic [7:0]  txl_q;
    logic [7:0]  rxl_q;
    logic [7:0]  fhi_q;
    logic [7:0]  flo_q;
    logic [duc_pkg::IRQ_W-1:0] ist_q;
    logic [duc_pkg::IRQ_W-1:0] msk_q;
    logic [duc_pkg::IRQ_W-1:0] ev;
    logic [duc_pkg::IRQ_W-1:0] clr;
    logic        tx_wready;
    logic        tx_val;
    logic [7:0]  tx_dat;
    logic [CW-1:0] tx_cnt;
    logic        tx_pop;
    logic        rx_wready;
    logic        rx_val;
    logic [7:0]  rx_dat;
    logic [CW-1:0] rx_cnt;
    logic [7:0]  rx_trig;
    logic [7:0]  tx_trig;
    logic        rx_hit;
    logic        tx_hit;
    logic        rxh_q;
    logic        txh_q;
    logic        par;
    logic        odd;
    logic [2:0]  rs_q;
    logic        filt_q;
    logic        rx_line;
    duc_pkg::duc_tx_state_e tst_q;
    logic [10:0] tsh_q;
    logic [3:0]  tn_q;
    logic [15:0] ttm_q;
    logic        so_q;
    duc_pkg::duc_rx_state_e rst_q;
    logic [8:0]  rsh_q;
    logic [3:0]  rn_q;
    logic [15:0] rtm_q;
    logic [7:0]  rdat_q;
    logic        rpush_q;
    logic        e_par_q;
    logic        e_frm_q;

    assign me    = (addr_q[duc_pkg::CHAN_SEL_BIT] == 1'(c)); // RULE_08
    assign we    = busw & me;
    assign re    = busr & me;
    assign srst  = we & (ofs == duc_pkg::OFS_CTRL) & HWDATA[duc_pkg::CTL_SOFT_RST];
    assign crst  = ~RST_N | srst; // RULE_13
    assign ext   = |{txl_q, rxl_q, fhi_q, flo_q}; // RULE_17
    assign flush = srst | (ext != ext_q);
    assign par   = ctrl_q[duc_pkg::CTL_PAR_EN];
    assign odd   = ctrl_q[duc_pkg::CTL_PAR_ODD];

    // software registers; reset clears the level registers, hence legacy mode
    always_ff @(posedge CLK_SYS) begin
      if (crst) begin
        ctrl_q <= duc_pkg::CTRL_RST; // RULE_13
        div_q  <= duc_pkg::DIV_RST;
        txl_q  <= 8'h00;
        rxl_q  <= 8'h00;
        fhi_q  <= 8'h00;
        flo_q  <= 8'h00;
        msk_q  <= '0;
        ext_q  <= 1'b0;
      end else begin
        ext_q <= ext;
        if (we) begin
          case (ofs) // RULE_15
            duc_pkg::OFS_CTRL:   ctrl_q <= HWDATA[15:0];
            duc_pkg::OFS_DIV:    div_q  <= HWDATA[15:0];
            duc_pkg::OFS_TXLVL:  txl_q  <= HWDATA[7:0];
            duc_pkg::OFS_RXLVL:  rxl_q  <= HWDATA[7:0];
            duc_pkg::OFS_FLOWHI: fhi_q  <= HWDATA[7:0];
            duc_pkg::OFS_FLOWLO: flo_q  <= HWDATA[7:0];
            duc_pkg::OFS_IMASK:  msk_q  <= HWDATA[duc_pkg::IRQ_W-1:0];
            default: ;
          endcase
        end
      end
    end

    // sticky status, write one to clear; a same-cycle event wins
    assign clr = (we && ofs == duc_pkg::OFS_ISTAT) ? HWDATA[duc_pkg::IRQ_W-1:0] : '0;
    always_ff @(posedge CLK_SYS) begin
      if (crst) begin
        ist_q <= '0;
      end else begin
        ist_q <= (ist_q & ~clr) | ev;
      end
    end
    assign irq_ch[c] = |(ist_q & msk_q);

    // fifos; a write to a full transmit fifo is dropped
    duc_fifo #(.W(8), .DEPTH(DEPTH), .CW(CW)) u_txf ( // RULE_11
      .clk      (CLK_SYS),
      .rst_n    (RST_N),
      .flush    (flush),
      .wr_valid (we && ofs == duc_pkg::OFS_DATA),
      .wr_ready (tx_wready),
      .wr_data  (HWDATA[7:0]),
      .rd_valid (tx_val),
      .rd_ready (tx_pop),
      .rd_data  (tx_dat),
      .count    (tx_cnt)
    );
    duc_fifo #(.W(8), .DEPTH(DEPTH), .CW(CW)) u_rxf ( // RULE_11
      .clk      (CLK_SYS),
      .rst_n    (RST_N),
      .flush    (flush),
      .wr_valid (rpush_q),
      .wr_ready (rx_wready),
      .wr_data  (rdat_q),
      .rd_valid (rx_val),
      .rd_ready (re && ofs == duc_pkg::OFS_DATA),
      .rd_data  (rx_dat),
      .count    (rx_cnt)
    );

    // trigger levels: table in legacy mode, level registers in extended mode
    always_comb begin
      if (ext) begin // RULE_12
        rx_trig = (rxl_q == 8'h00) ? 8'h01 : rxl_q;
        tx_trig = (txl_q == 8'h00) ? 8'h01 : txl_q;
      end else begin
        rx_trig = duc_pkg::RX_TRIG_TBL[ctrl_q[duc_pkg::CTL_TRIG_LO +: 2]];
        tx_trig = duc_pkg::TX_TRIG_TBL[ctrl_q[duc_pkg::CTL_TRIG_LO +: 2]];
      end
    end
    assign rx_hit = (rx_cnt >= rx_trig);
    assign tx_hit = ((CW'(DEPTH) - tx_cnt) >= tx_trig);

    // edge of each trigger condition so a cleared flag is not refilled at once
    always_ff @(posedge CLK_SYS) begin
      if (crst) begin
        rxh_q <= 1'b0;
        txh_q <= 1'b1; // an empty fifo has room, so no false event right after reset
      end else begin
        rxh_q <= rx_hit;
        txh_q <= tx_hit;
      end
    end
    assign ev[duc_pkg::IRQ_RX_TRIG] = rx_hit & ~rxh_q;
    assign ev[duc_pkg::IRQ_TX_TRIG] = tx_hit & ~txh_q;
    assign ev[duc_pkg::IRQ_PARITY]  = e_par_q;
    assign ev[duc_pkg::IRQ_FRAME]   = e_frm_q;
    assign ev[duc_pkg::IRQ_OVERRUN] = rpush_q & ~rx_wready;

    // ready pins: rx waits for the trigger in block mode, for one char in single mode; tx shows a free slot in both
    assign rxr_n[c] = ctrl_q[duc_pkg::CTL_DMA_BLK] ? ~(rx_hit & rx_val) : ~rx_val; // RULE_01 RULE_02 RULE_05
    assign txr_n[c] = ~tx_wready; // RULE_03 RULE_04 RULE_05

    // receive pin: three stages, change accepted once stages two and three agree
    always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
        rs_q   <= 3'h7;
        filt_q <= 1'b1; // RULE_16
      end else begin
        rs_q <= {rs_q[1:0], si[c]};
        if (rs_q[1] == rs_q[2]) begin
          filt_q <= rs_q[2];
        end
      end
    end
    assign rx_line = ctrl_q[duc_pkg::CTL_LOOP] ? tsh_q[0] : filt_q; // RULE_07 RULE_16

    // transmitter; shift register fills with ones so its lsb idles high
    assign tx_pop = (tst_q == duc_pkg::TX_IDLE) & ctrl_q[duc_pkg::CTL_TX_EN] & tx_val;
    always_ff @(posedge CLK_SYS) begin
      if (crst) begin
        tst_q <= duc_pkg::TX_IDLE;
        tsh_q <= 11'h7FF;
        tn_q  <= 4'h0;
        ttm_q <= 16'h0000;
      end else begin
        case (tst_q)
          duc_pkg::TX_IDLE: begin
            if (tx_pop) begin
              if (par) begin
                tsh_q <= {1'b1, ^tx_dat ^ odd, tx_dat, 1'b0}; // RULE_09 RULE_10
                tn_q  <= 4'hB;
              end else begin
                tsh_q <= {2'b11, tx_dat, 1'b0}; // RULE_09
                tn_q  <= 4'hA;
              end
              ttm_q <= div_q - 16'h0001;
              tst_q <= duc_pkg::TX_RUN;
            end
          end
          duc_pkg::TX_RUN: begin
            if (ttm_q == 16'h0000) begin
              tsh_q <= {1'b1, tsh_q[10:1]};
              tn_q  <= tn_q - 4'h1;
              ttm_q <= div_q - 16'h0001;
              if (tn_q == 4'h1) begin
                tst_q <= duc_pkg::TX_IDLE;
              end
            end else begin
              ttm_q <= ttm_q - 16'h0001;
            end
          end
          default: tst_q <= duc_pkg::TX_IDLE;
        endcase
      end
    end

    // pin held high in reset, in loopback and while the transmitter is off
    always_ff @(posedge CLK_SYS) begin
      if (crst) begin
        so_q <= 1'b1; // RULE_06
      end else begin
        so_q <= (ctrl_q[duc_pkg::CTL_LOOP] | ~ctrl_q[duc_pkg::CTL_TX_EN]) ? 1'b1 : tsh_q[0]; // RULE_06 RULE_07
      end
    end
    assign so[c] = so_q;

    // receiver: centre of start bit found after half a bit time, then full bits
    always_ff @(posedge CLK_SYS) begin
      if (crst) begin
        rst_q   <= duc_pkg::RX_IDLE;
        rsh_q   <= 9'h000;
        rn_q    <= 4'h0;
        rtm_q   <= 16'h0000;
        rdat_q  <= 8'h00;
        rpush_q <= 1'b0;
        e_par_q <= 1'b0;
        e_frm_q <= 1'b0;
      end else begin
        rpush_q <= 1'b0;
        e_par_q <= 1'b0;
        e_frm_q <= 1'b0;
        case (rst_q)
          duc_pkg::RX_IDLE: begin
            if (ctrl_q[duc_pkg::CTL_RX_EN] && !rx_line) begin
              rtm_q <= {1'b0, div_q[15:1]};
              rst_q <= duc_pkg::RX_START;
            end
          end
          duc_pkg::RX_START: begin
            if (rtm_q == 16'h0000) begin
              rn_q  <= 4'h0;
              rtm_q <= div_q - 16'h0001;
              rst_q <= rx_line ? duc_pkg::RX_IDLE : duc_pkg::RX_DATA; // glitch rejected
            end else begin
              rtm_q <= rtm_q - 16'h0001;
            end
          end
          duc_pkg::RX_DATA: begin
            if (rtm_q == 16'h0000) begin
              rsh_q <= {rx_line, rsh_q[8:1]};
              rn_q  <= rn_q + 4'h1;
              rtm_q <= div_q - 16'h0001;
              if (rn_q == (par ? 4'h8 : 4'h7)) begin
                rst_q <= duc_pkg::RX_STOP;
              end
            end else begin
              rtm_q <= rtm_q - 16'h0001;
            end
          end
          duc_pkg::RX_STOP: begin
            if (rtm_q == 16'h0000) begin
              rdat_q  <= par ? rsh_q[7:0] : rsh_q[8:1]; // RULE_09
              rpush_q <= 1'b1;
              e_frm_q <= ~rx_line; // RULE_09
              e_par_q <= par & (rsh_q[8] != (^rsh_q[7:0] ^ odd)); // RULE_10
              rst_q   <= duc_pkg::RX_IDLE;
            end else begin
              rtm_q <= rtm_q - 16'h0001;
            end
          end
          default: rst_q <= duc_pkg::RX_IDLE;
        endcase
      end
    end

    // register read view; a data read also pops the receive fifo
    always_comb begin
      case (ofs)
        duc_pkg::OFS_DATA:   rd_val[c] = {23'h00_0000, ~rx_val, rx_dat};
        duc_pkg::OFS_CTRL:   rd_val[c] = 32'(ctrl_q);
        duc_pkg::OFS_DIV:    rd_val[c] = 32'(div_q);
        duc_pkg::OFS_TXLVL:  rd_val[c] = 32'(txl_q);
        duc_pkg::OFS_RXLVL:  rd_val[c] = 32'(rxl_q);
        duc_pkg::OFS_FLOWHI: rd_val[c] = 32'(fhi_q);
        duc_pkg::OFS_FLOWLO: rd_val[c] = 32'(flo_q);
        duc_pkg::OFS_STATUS: rd_val[c] = {13'h0000, rst_q != duc_pkg::RX_IDLE,
                                          tst_q != duc_pkg::TX_IDLE, ext, tx_cnt, rx_cnt};
        duc_pkg::OFS_ISTAT:  rd_val[c] = 32'(ist_q);
        duc_pkg::OFS_IMASK:  rd_val[c] = 32'(msk_q);
        default:             rd_val[c] = 32'h0000_0000;
      endcase
    end
  end

endmodule

// >>> verification/duc_props.sv
// checker for the dual uart pair: bus timing, reset levels, ready pins
`timescale 1ns/1ps
module duc_props (
  input wire logic        CLK_SYS,           // clock
  input wire logic        RST_N,             // reset
  input wire logic        HSEL,              // select
  input wire logic [31:0] HADDR,             // address
  input wire logic [1:0]  HTRANS,            // type
  input wire logic        HWRITE,            // write
  input wire logic        HREADY,            // ready in
  input wire logic [31:0] HRDATA,            // read data
  input wire logic        HREADYOUT,         // ready out
  input wire logic        SERIAL_OUT_CHAN_B, // tx pin b
  input wire logic        RX_READY_N_CHAN_A, // rx ready a
  input wire logic        TX_READY_N_CHAN_B, // tx ready b
  input wire logic        IRQ                // interrupt
);
  // ****
  // properties
  // ****
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // taken transfer and its write flavour, kept for looking back
  wire logic tk = HSEL & HTRANS[1] & HREADY;
  wire logic tw = tk & HWRITE;
  sequence s_take; tk; endsequence
  sequence s_wait; !HREADYOUT ##1 HREADYOUT; endsequence
  a_one_wait: assert property (s_take |=> s_wait)
    else $error("wait state not exactly one cycle");
  a_no_stray_wait: assert property (!HREADYOUT |-> $past(tk))
    else $error("wait state without a transfer");
  a_reset_levels: assert property ($rose(RST_N) |-> SERIAL_OUT_CHAN_B
    && RX_READY_N_CHAN_A && !TX_READY_N_CHAN_B && !IRQ) else $error("outputs not at rest");
  a_unsel_zero: assert property (tk && !HWRITE && HADDR[7]
    |-> ##2 HRDATA == 32'h0000_0000) else $error("unselected read not zero");
  a_start_width: assert property ($fell(SERIAL_OUT_CHAN_B) |=> !SERIAL_OUT_CHAN_B)
    else $error("start bit too short");
  a_rx_pop_only: assert property ($rose(RX_READY_N_CHAN_A)
    |-> $past(tk) || $past(tk, 2) || $past(tk, 3)) else $error("rx ready rose unasked");
  a_full_by_push: assert property ($rose(TX_READY_N_CHAN_B)
    |-> $past(tw) || $past(tw, 2) || $past(tw, 3)) else $error("tx ready rose unasked");
  a_irq_clear_wr: assert property ($fell(IRQ)
    |-> $past(tw, 2) || $past(tw, 3) || $past(tw, 4)) else $error("irq fell unasked");
endmodule

// >>> verification/duc_line_model.sv
// serial far end: sends frames into a receive pin, captures frames from a transmit pin
`timescale 1ns/1ps
module duc_line_model #(
  parameter int D = 8 // clocks per bit, matches the divisor written
) (
  input  wire logic clk,  // system clock
  output logic      sin,  // drives the receive pin
  input  wire logic sout  // watches the transmit pin
);
  // an idle line rests high like a pulled-up input
  initial sin = 1'b1;
  // start, nine bits lsb first (data then parity as given), stop
  task automatic send(input logic [8:0] b);
    sin <= 1'b0;
    repeat (D) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      sin <= b[i];
      repeat (D) @(posedge clk);
    end
    sin <= 1'b1;
    repeat (D) @(posedge clk);
  endtask
  // mid-bit sampling; waits until a frame arrives, the watchdog bounds it
  task automatic recv(output logic [7:0] b);
    @(negedge sout);
    repeat (D / 2 + D) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      b[i] = sout;
      repeat (D) @(posedge clk);
    end
  endtask
endmodule

// >>> verification/tb.sv
// top bench for the dual uart pair: bus tasks, serial traffic, verdict
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, iso = 1'b0, sin_a = 1'b1;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, q;
  logic [7:0]  b8;
  wire logic   hready, hresp, so_a, so_b, sin_b, rxn_a, rxn_b, txn_a, txn_b, irq;
  wire logic [31:0] hrdata;
  int          n_mismatch = 0, compares = 0;
  duc_top DUT (.CLK_SYS(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'b010), .HREADY(hready), .HWDATA(hwdata), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .HOST_BUS_ISOLATE(iso), .SERIAL_IN_CHAN_A(sin_a),
    .SERIAL_IN_CHAN_B(sin_b), .SERIAL_OUT_CHAN_A(so_a), .SERIAL_OUT_CHAN_B(so_b),
    .RX_READY_N_CHAN_A(rxn_a), .RX_READY_N_CHAN_B(rxn_b), .TX_READY_N_CHAN_A(txn_a),
    .TX_READY_N_CHAN_B(txn_b), .IRQ(irq));
  duc_line_model #(.D(8)) PM (.clk(clk), .sin(sin_b), .sout(so_b));
  // ****
  // bus and compare tasks
  // ****
  // one single transfer; the master waits for ready and never counts cycles
  task automatic xfer(input logic s, w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= s;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, 1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b1, 1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // clock and watchdog; a hang counts as a mismatch
  initial forever #5 clk = ~clk;
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report;
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(negedge clk);
    chk({so_a, so_b, rxn_a, rxn_b, txn_a, txn_b, irq, hresp}, 8'hF0);
    rd(8'h04, 32'h0000_0003);
    rd(8'h08, 32'h0000_0364);
    wr(8'h08, 32'h0000_0008);
    wr(8'h48, 32'h0000_0008);
    wr(8'h44, 32'h0000_000B);
    iso <= 1'b1;
    repeat (6) @(posedge clk);
    wr(8'h08, 32'h0000_0055);
    rd(8'h08, 32'h0000_0000);
    iso <= 1'b0;
    repeat (6) @(posedge clk);
    rd(8'h08, 32'h0000_0008);
    wr(8'h88, 32'h0000_0077);
    rd(8'h88, 32'h0000_0000);
    xfer(1'b0, 1'b1, 8'h08, 32'h0000_0099);
    rd(8'h08, 32'h0000_0008);
    rd(8'h48, 32'h0000_0008);
    // receive on b with even parity: good frame, then a bad parity bit
    PM.send(9'h03C);
    repeat (12) @(negedge clk);
    chk(rxn_b, 1'b0);
    rd(8'h40, 32'h0000_003C);
    repeat (2) @(negedge clk);
    chk(rxn_b, 1'b1);
    PM.send(9'h13C);
    repeat (12) @(negedge clk);
    chk(irq, 1'b0);
    xfer(1'b1, 1'b0, 8'h60, 32'h0000_0000);
    chk(q, 32'h0000_0004);
    wr(8'h64, 32'h0000_0004);
    repeat (3) @(negedge clk);
    chk(irq, 1'b1);
    wr(8'h60, 32'h0000_0004);
    repeat (3) @(negedge clk);
    chk(irq, 1'b0);
    rd(8'h40, 32'h0000_003C);
    // transmit on b, then fill its fifo with the transmitter off
    fork
      PM.recv(b8);
      wr(8'h40, 32'h0000_00A5);
    join
    chk(b8, 8'hA5);
    repeat (30) @(negedge clk);
    chk(so_b, 1'b1);
    wr(8'h44, 32'h0000_0022);
    for (int i = 0; i < 127; i++) wr(8'h40, 32'(i));
    repeat (2) @(negedge clk);
    chk(txn_b, 1'b0);
    wr(8'h40, 32'h0000_00FF);
    repeat (2) @(negedge clk);
    chk(txn_b, 1'b1);
    wr(8'h44, 32'h0000_8000);
    repeat (2) @(negedge clk);
    chk(txn_b, 1'b0);
    // loopback on a while the outside pin is pulled low and must be ignored
    wr(8'h04, 32'h0000_0007);
    sin_a <= 1'b0;
    wr(8'h00, 32'h0000_005A);
    repeat (120) @(negedge clk) chk(so_a, 1'b1);
    @(posedge clk);
    sin_a <= 1'b1;
    chk(rxn_a, 1'b0);
    rd(8'h00, 32'h0000_005A);
    wr(8'h10, 32'h0000_0001);
    xfer(1'b1, 1'b0, 8'h1C, 32'h0000_0000);
    chk(q, 32'h0001_0000);
    final_report;
  end
endmodule
bind duc_top duc_props P (.CLK_SYS, .RST_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HREADY,
  .HRDATA, .HREADYOUT, .SERIAL_OUT_CHAN_B, .RX_READY_N_CHAN_A, .TX_READY_N_CHAN_B, .IRQ);
